// file: rtl/irap_map.svh
// Register offsets, field positions, reset values and bus constants of the access port
`ifndef IRAP_MAP_SVH
`define IRAP_MAP_SVH

// Target address, 7 bits: address byte 8'hD0 for writes, 8'hD1 for reads
`define IRAP_DEV_ADDR 7'h68

`define IRAP_OFS_RELEASE_ID 8'h00
`define IRAP_OFS_REF_CLK 8'h01
`define IRAP_OFS_MST_CLK 8'h02
`define IRAP_OFS_AUX_CLK 8'h03

`define IRAP_REF_CLK_RST 8'h00
`define IRAP_MST_CLK_RST 8'h00
`define IRAP_AUX_CLK_RST 8'h00

// Bit 7 of the reference clock register selects the 100/16 synthesised master clock
`define IRAP_PLL_SEL_BIT 7
// Bit 7 of the master clock register holds standby
`define IRAP_STANDBY_BIT 7

// Serial clock ratio limits the host must keep (standby, normal)
`define IRAP_STBY_SCL_RATIO 10
`define IRAP_NORM_SCL_RATIO 40

`define IRAP_BIT_CNT_FULL 4'h8
`define IRAP_STRAP_LOAD_CNT 2'h2
`define IRAP_STRAP_DONE_CNT 2'h3

`endif

// file: rtl/irap_pkg.sv
// Types shared by the register access port
package irap_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_TURN,
        ST_RDATA,
        ST_RACK
    } irap_state_t;

endpackage

// file: rtl/irap_bank.sv
// Register bank storage with registered read data
module irap_bank (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o
);

    logic [7:0] mem [0:255];

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule // irap_bank

// file: rtl/irap_port.sv
// I2C target port giving the host access to the register bank
`include "irap_map.svh"
// Summary of operation
// - Answer address byte D0 for writes, D1 for reads; host opens with it.
// - In normal write, the byte after the address loads the register pointer.
// - Normal mode: each data byte goes to the pointed register, pointer then advances.
// - A normal write keeps taking bytes until a stop is seen.
// - Acknowledge every received byte of an addressed transfer.
// - Normal read returns the pointed register, then successive ones, advancing after each byte the host acknowledges.
// - In standby only registers 01, 02, 03 are reachable, read and write.
// - In standby one register per transfer, pointer never advances.
// - After reset the port is in normal mode with full access when the standby pin is low, in standby when it is high.
// - Master clock is clock input when strap low, 100/16 of it when high.
// - Register 00 reports the silicon release code.
// - A written compatible release code reads back, otherwise own code is returned.
// - Reset release loads standby and clock-select bits from their pins.
// - Clock registers stay reachable while the master clock is stopped.
module irap_port #(
    // Arbitrary value
    parameter logic [7:0] OWN_RELEASE = 8'h5C,
    // Arbitrary value
    parameter logic [7:0] COMPAT_RELEASE = 8'h5B
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic standby_pin_i,
    input wire logic direct_clock_disable_input_i,
    output logic standby_o,
    output logic pll_clock_sel_o,
    output logic [7:0] reference_clock_ctrl_o,
    output logic [7:0] master_clock_ctrl_o,
    output logic [7:0] auxiliary_clock_ctrl_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0] scl_sync, sda_sync, stby_sync, dcd_sync;
    logic scl_d, sda_d;
    logic scl_s, sda_s;

    // port clock
    // Runs on clock_i only, which keeps going when the master clock is stopped
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            stby_sync <= 2'h0;
            dcd_sync <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            stby_sync <= {stby_sync[0], standby_pin_i};
            dcd_sync <= {dcd_sync[0], direct_clock_disable_input_i};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture after reset release

    logic [1:0] init_cnt, next_init_cnt;
    logic load_strap;

    // Waits for the synchronisers to fill before trusting the pin levels
    assign load_strap = (init_cnt == `IRAP_STRAP_LOAD_CNT);

    always_comb begin
        next_init_cnt = init_cnt;
        if (init_cnt != `IRAP_STRAP_DONE_CNT) begin
            next_init_cnt = init_cnt + 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            init_cnt <= 2'h0;
        end else begin
            init_cnt <= next_init_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer state machine and clock registers

    irap_pkg::irap_state_t st, next_st, after_st, next_after_st;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, txbuf, next_txbuf, ptr, next_ptr;
    logic sda_oe, next_sda_oe, access_done, next_access_done;
    logic [7:0] ref_clk, next_ref_clk, mst_clk, next_mst_clk, aux_clk, next_aux_clk;
    logic [7:0] id_wr, next_id_wr;
    logic [7:0] rd_value, mem_rdata;
    logic mem_we, standby, clk_reg_sel, byte_done, wr_ok, rack_ok;

    assign standby = mst_clk[`IRAP_STANDBY_BIT];
    assign clk_reg_sel = (ptr == `IRAP_OFS_REF_CLK) || (ptr == `IRAP_OFS_MST_CLK)
        || (ptr == `IRAP_OFS_AUX_CLK);
    assign byte_done = scl_fall && (bit_cnt == `IRAP_BIT_CNT_FULL);
    assign wr_ok = !standby || (clk_reg_sel && !access_done);
    assign rack_ok = (st == irap_pkg::ST_RACK) && scl_rise && !sda_s;

    always_comb begin
        rd_value = mem_rdata;
        if (standby && !clk_reg_sel) begin
            rd_value = 8'h00;
        end else if (ptr == `IRAP_OFS_RELEASE_ID) begin
            rd_value = (id_wr == COMPAT_RELEASE) ? id_wr : OWN_RELEASE;
        end else if (ptr == `IRAP_OFS_REF_CLK) begin
            rd_value = ref_clk;
        end else if (ptr == `IRAP_OFS_MST_CLK) begin
            rd_value = mst_clk;
        end else if (ptr == `IRAP_OFS_AUX_CLK) begin
            rd_value = aux_clk;
        end
    end

    always_comb begin
        next_st = st;
        next_after_st = after_st;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_txbuf = txbuf;
        next_ptr = ptr;
        next_sda_oe = sda_oe;
        next_access_done = access_done;
        next_ref_clk = ref_clk;
        next_mst_clk = mst_clk;
        next_aux_clk = aux_clk;
        next_id_wr = id_wr;
        mem_we = 1'b0;
        if (load_strap) begin
            next_ref_clk[`IRAP_PLL_SEL_BIT] = dcd_sync[1];
            next_mst_clk[`IRAP_STANDBY_BIT] = stby_sync[1];
        end
        if (stop_det) begin
            next_st = irap_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_det) begin
            next_st = irap_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (st)
                irap_pkg::ST_ADDR, irap_pkg::ST_PTR, irap_pkg::ST_WDATA: begin
                    if (scl_rise && bit_cnt != `IRAP_BIT_CNT_FULL) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe = 1'b1;
                        next_st = irap_pkg::ST_TURN;
                        if (st == irap_pkg::ST_ADDR) begin
                            if (shreg[7:1] != `IRAP_DEV_ADDR) begin
                                next_st = irap_pkg::ST_IDLE;
                                next_sda_oe = 1'b0;
                            end else if (shreg[0]) begin
                                next_after_st = irap_pkg::ST_RDATA;
                            end else begin
                                next_after_st = irap_pkg::ST_PTR;
                            end
                        end else if (st == irap_pkg::ST_PTR) begin
                            next_ptr = shreg;
                            next_access_done = 1'b0;
                            next_after_st = irap_pkg::ST_WDATA;
                        end else begin
                            next_after_st = irap_pkg::ST_WDATA;
                            if (wr_ok) begin
                                if (ptr == `IRAP_OFS_RELEASE_ID) begin
                                    next_id_wr = shreg;
                                end else if (ptr == `IRAP_OFS_REF_CLK) begin
                                    next_ref_clk = shreg;
                                end else if (ptr == `IRAP_OFS_MST_CLK) begin
                                    next_mst_clk = shreg;
                                end else if (ptr == `IRAP_OFS_AUX_CLK) begin
                                    next_aux_clk = shreg;
                                end else begin
                                    mem_we = 1'b1;
                                end
                                next_access_done = standby;
                                if (!standby) begin
                                    next_ptr = ptr + 8'h01;
                                end
                            end
                        end
                    end
                end
                irap_pkg::ST_TURN: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_st = after_st;
                        next_bit_cnt = 4'h0;
                        if (after_st == irap_pkg::ST_RDATA) begin
                            next_txbuf = rd_value;
                            next_sda_oe = ~rd_value[7];
                        end
                    end
                end
                irap_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            next_sda_oe = 1'b0;
                            next_st = irap_pkg::ST_RACK;
                        end else begin
                            next_txbuf = {txbuf[6:0], 1'b0};
                            next_sda_oe = ~txbuf[6];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                irap_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            next_st = irap_pkg::ST_IDLE;
                        end else begin
                            if (!standby) begin
                                next_ptr = ptr + 8'h01;
                            end
                            next_after_st = irap_pkg::ST_RDATA;
                            next_st = irap_pkg::ST_TURN;
                        end
                    end
                end
                default: begin
                    next_st = irap_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= irap_pkg::ST_IDLE;
            after_st <= irap_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            txbuf <= 8'h00;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
            access_done <= 1'b0;
            ref_clk <= `IRAP_REF_CLK_RST;
            mst_clk <= `IRAP_MST_CLK_RST;
            aux_clk <= `IRAP_AUX_CLK_RST;
            id_wr <= 8'h00;
        end else begin
            st <= next_st;
            after_st <= next_after_st;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            txbuf <= next_txbuf;
            ptr <= next_ptr;
            sda_oe <= next_sda_oe;
            access_done <= next_access_done;
            ref_clk <= next_ref_clk;
            mst_clk <= next_mst_clk;
            aux_clk <= next_aux_clk;
            id_wr <= next_id_wr;
        end
    end

    irap_bank u_bank (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .we_i(mem_we),
        .waddr_i(ptr),
        .wdata_i(shreg),
        .raddr_i(ptr),
        .rdata_o(mem_rdata)
    );

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe;
    assign standby_o = standby;
    assign pll_clock_sel_o = ref_clk[`IRAP_PLL_SEL_BIT];
    assign reference_clock_ctrl_o = ref_clk;
    assign master_clock_ctrl_o = mst_clk;
    assign auxiliary_clock_ctrl_o = aux_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    chk_addr_ack: assert property (
        byte_done && st == irap_pkg::ST_ADDR && shreg[7:1] == `IRAP_DEV_ADDR
        |=> st == irap_pkg::ST_TURN && sda_oe)
        else $error("own address not acknowledged");
    chk_foreign_addr: assert property (
        byte_done && st == irap_pkg::ST_ADDR && shreg[7:1] != `IRAP_DEV_ADDR
        && !stop_det && !start_det |=> st == irap_pkg::ST_IDLE && !sda_oe)
        else $error("foreign address answered");
    chk_ptr_load: assert property (
        byte_done && st == irap_pkg::ST_PTR && !stop_det && !start_det
        |=> ptr == $past(shreg))
        else $error("pointer not loaded");
    chk_write_incr: assert property (
        byte_done && st == irap_pkg::ST_WDATA && !standby && !stop_det && !start_det
        |=> ptr == $past(ptr) + 8'h01 && sda_oe)
        else $error("write did not advance pointer");
    chk_stop_idle: assert property (
        stop_det |=> st == irap_pkg::ST_IDLE && !sda_oe)
        else $error("stop not honoured");
    chk_read_incr: assert property (
        rack_ok && !standby && !stop_det && !start_det |=> ptr == $past(ptr) + 8'h01)
        else $error("read did not advance pointer");
    chk_stby_noinc: assert property (
        standby && st != irap_pkg::ST_PTR |=> $stable(ptr))
        else $error("pointer moved in standby");
    chk_stby_bank: assert property (
        standby |-> !mem_we)
        else $error("bank written in standby");
    chk_strap_load: assert property (
        load_strap |=> standby == $past(stby_sync[1])
        && pll_clock_sel_o == $past(dcd_sync[1]))
        else $error("strap not loaded");

    cov_write: cover property (byte_done && st == irap_pkg::ST_WDATA && !standby);
    cov_read: cover property (rack_ok);
    cov_stby_write: cover property (byte_done && st == irap_pkg::ST_WDATA && standby);
    cov_nack: cover property (st == irap_pkg::ST_RACK && scl_rise && sda_s);

endmodule // irap_port

// file: verification/irap_host.sv
// Behavioural I2C bus master driving the register access port
module irap_host (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // SCL period of 96 cycles, well above both ratio limits
    localparam int HALF = 48;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Also serves as repeated start, since SCL is low between bytes
    task automatic start_cond();
        wait_clk(HALF / 2);
        sda_o <= 1'b1;
        wait_clk(HALF / 2);
        scl_o <= 1'b1;
        wait_clk(HALF / 2);
        sda_o <= 1'b0;
        wait_clk(HALF / 2);
        scl_o <= 1'b0;
    endtask
    task automatic stop_cond();
        wait_clk(HALF / 2);
        sda_o <= 1'b0;
        wait_clk(HALF / 2);
        scl_o <= 1'b1;
        wait_clk(HALF / 2);
        sda_o <= 1'b1;
        wait_clk(HALF);
    endtask
    // SDA changes only mid-low and is sampled mid-high; a released line reads the pull-up
    task automatic clock_bit(input logic b, output logic s);
        wait_clk(HALF / 2);
        sda_o <= b;
        wait_clk(HALF / 2);
        scl_o <= 1'b1;
        wait_clk(HALF / 2);
        s = sda_i;
        wait_clk(HALF / 2);
        scl_o <= 1'b0;
    endtask
    // first byte of each transfer is the address byte
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, ack);
    endtask
    // Host acknowledges all but the last byte of a read
    task automatic read_byte(input logic last);
        logic s;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(last, s);
        rd_data_o <= d;
        rd_valid_o <= 1'b1;
        wait_clk(1);
        rd_valid_o <= 1'b0;
    endtask
endmodule // irap_host

// file: verification/testbench.sv
// Self-checking bench for the register access port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary value
    localparam logic [7:0] OWN_ID = 8'h3E;
    // Arbitrary value
    localparam logic [7:0] COMPAT_ID = 8'h3D;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic standby_pin_i = 1'b0;
    logic dcd_pin = 1'b1;
    logic scl, host_sda, sda_line, sda_o, sda_oe_o, standby_o, pll_clock_sel_o, rd_valid;
    logic [7:0] ref_q, mst_q, aux_q, rd_data;
    logic [7:0] expq[$];
    int err_count = 0;
    int compares = 0;
    int seed = 33331;
    always #4 clock_i = ~clock_i;
    // Open drain with pull-up; while enabled the port pulls the wire low, its sda_o being tied to 0
    assign sda_line = host_sda & (sda_oe_o ? sda_o : 1'b1);
    irap_port #(.OWN_RELEASE(OWN_ID), .COMPAT_RELEASE(COMPAT_ID)) u_irap_port (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_pin_i(standby_pin_i),
        .direct_clock_disable_input_i(dcd_pin), .standby_o(standby_o),
        .pll_clock_sel_o(pll_clock_sel_o), .reference_clock_ctrl_o(ref_q),
        .master_clock_ctrl_o(mst_q), .auxiliary_clock_ctrl_o(aux_q)
    );
    irap_host u_host (
        .clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] data[$]);
        logic ack;
        u_host.start_cond();
        u_host.write_byte(8'hD0, ack);
        check("address ack", {7'h00, ack}, 8'h00);
        u_host.write_byte(ptr, ack);
        check("pointer ack", {7'h00, ack}, 8'h00);
        foreach (data[i]) begin
            u_host.write_byte(data[i], ack);
            check("data ack", {7'h00, ack}, 8'h00);
        end
        u_host.stop_cond();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        logic ack;
        logic [7:0] none[$];
        wr(ptr, none);
        u_host.start_cond();
        u_host.write_byte(8'hD1, ack);
        check("read address ack", {7'h00, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            u_host.read_byte(i == n - 1);
        end
        u_host.stop_cond();
    endtask
    task automatic do_reset(input logic stby, input logic dcd);
        @(posedge clock_i);
        arst_n_i <= 1'b0;
        standby_pin_i <= stby;
        dcd_pin <= dcd;
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        check("standby flag", {7'h00, standby_o}, {7'h00, stby});
        check("clock select", {7'h00, pll_clock_sel_o}, {7'h00, dcd});
        check("reference clock reg", ref_q, {dcd, 7'h00});
        check("master clock reg", mst_q, {stby, 7'h00});
        check("auxiliary clock reg", aux_q, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Each read byte is compared with the oldest expected note
    always @(posedge clock_i) begin
        if (rd_valid === 1'b1) begin
            check("read data", rd_data, expq.pop_front());
        end
    end
    // Traffic takes about 67000 cycles at 864 cycles a byte; the rest is margin
    initial begin
        repeat (90000) @(posedge clock_i);
        err_count++;
        results();
    end
    initial begin
        logic [7:0] bq[$];
        logic ack;
        do_reset(1'b0, 1'b1);
        $display("test reset straps done");
        wr(8'h01, '{8'h35, 8'h4C, 8'hA7});
        check("reference clock reg", ref_q, 8'h35);
        check("master clock reg", mst_q, 8'h4C);
        check("auxiliary clock reg", aux_q, 8'hA7);
        check("clock select", {7'h00, pll_clock_sel_o}, 8'h00);
        expq.push_back(8'h35);
        expq.push_back(8'h4C);
        expq.push_back(8'hA7);
        rd(8'h01, 3);
        for (int i = 0; i < 5; i++) begin
            bq.push_back(8'($random(seed)));
            expq.push_back(bq[i]);
        end
        wr(8'h10, bq);
        rd(8'h10, 5);
        $display("test normal write and read done");
        u_host.start_cond();
        u_host.write_byte(8'hD4, ack);
        check("foreign address ack", {7'h00, ack}, 8'h01);
        u_host.stop_cond();
        $display("test foreign address done");
        expq.push_back(OWN_ID);
        rd(8'h00, 1);
        wr(8'h00, '{COMPAT_ID});
        expq.push_back(COMPAT_ID);
        rd(8'h00, 1);
        wr(8'h00, '{8'h77});
        expq.push_back(OWN_ID);
        rd(8'h00, 1);
        $display("test release id done");
        wr(8'h02, '{8'h80});
        check("standby flag", {7'h00, standby_o}, 8'h01);
        wr(8'h03, '{8'h11, 8'h22});
        check("auxiliary clock reg", aux_q, 8'h11);
        expq.push_back(8'h35);
        expq.push_back(8'h35);
        rd(8'h01, 2);
        wr(8'h10, '{8'h99});
        expq.push_back(8'h00);
        rd(8'h10, 1);
        wr(8'h02, '{8'h00});
        check("standby flag", {7'h00, standby_o}, 8'h00);
        expq.push_back(bq[0]);
        rd(8'h10, 1);
        $display("test standby access done");
        do_reset(1'b1, 1'($random(seed)));
        $display("test second reset done");
        check("pending reads", 8'(expq.size()), 8'h00);
        results();
    end
endmodule // testbench
